// >>> core/pcs_pkg.sv
package pcs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PCS_OFS_PIN_CTRL  = 8'h64;
  localparam logic [7:0] PCS_OFS_ADDR_STAT = 8'h65;
  localparam logic [7:0] PCS_OFS_CLK_CTRL  = 8'h66;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PCS_SDA_FUNC_LSB = 6;
  localparam int PCS_SDA_OUT_BIT  = 5;
  localparam int PCS_SDA_IN_BIT   = 4;
  localparam int PCS_SCL_FUNC_LSB = 2;
  localparam int PCS_SCL_OUT_BIT  = 1;
  localparam int PCS_SCL_IN_BIT   = 0;
  localparam int PCS_STRAP_BIT    = 6;
  localparam int PCS_DIV_SRC_LSB  = 6;
  localparam int PCS_PLL_SRC_LSB  = 4;
  localparam int PCS_PLL_N_LSB    = 0;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [1:0] PCS_FUNC_RST    = 2'h0;
  localparam logic       PCS_OUT_RST     = 1'h0;
  localparam logic [1:0] PCS_SRC_RST     = 2'h0;
  localparam logic [3:0] PCS_PLL_N_RST   = 4'h2;
  localparam logic [1:0] PCS_SRC_RSVD    = 2'h3;
  localparam logic [6:0] PCS_ADDR_A_LOW  = 7'h18;
  localparam logic [6:0] PCS_ADDR_A_HIGH = 7'h1A;
  localparam logic [6:0] PCS_ADDR_B_LOW  = 7'h19;
  localparam logic [6:0] PCS_ADDR_B_HIGH = 7'h1B;
  localparam logic [4:0] PCS_PLL_N_WRAP  = 5'h10;

  typedef enum logic [1:0] {
    PCS_PIN_BUS,
    PCS_PIN_GPI,
    PCS_PIN_GPO,
    PCS_PIN_RSVD
  } pcs_pin_mode_t;

  typedef enum logic [1:0] {
    PCS_SRC_MASTER_CLK,
    PCS_SRC_SECOND_AUX_PIN,
    PCS_SRC_BIT_CLK,
    PCS_SRC_RESERVED
  } pcs_clk_src_t;

  // Register access from the control-bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcs_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pcs_rsp_t;

endpackage : pcs_pkg

// >>> core/pcs_regs.sv
`timescale 1ns/100ps
module pcs_regs
  import pcs_pkg::*;
#(
  parameter bit CODEC_B = 1'b0
)
(
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire pcs_req_t     reg_req,
  output pcs_rsp_t          reg_rsp,
  input  wire logic         bus_sda_pull,
  input  wire logic         bus_scl_pull,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe,
  input  wire logic         addr_strap,
  output logic [6:0]        bus_addr,
  output pcs_clk_src_t      divider_input_clock,
  output pcs_clk_src_t      pll_input_clock,
  output logic [4:0]        pll_n_value
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic pcs_pin_mode_t pin_mode(input logic [1:0] code);
    pin_mode = pcs_pin_mode_t'(code);
  endfunction : pin_mode

  function automatic logic pin_pull(input logic [1:0] code, input logic lvl,
                                    input logic bus_pull);
    case (pin_mode(code))
      PCS_PIN_BUS: pin_pull = bus_pull;
      PCS_PIN_GPO: pin_pull = ~lvl;
      default:     pin_pull = 1'b0;
    endcase
  endfunction : pin_pull

  // ****************************************
  // Storage
  // ****************************************
  logic [1:0]   sda_func_ff;
  logic         sda_out_ff;
  logic         sda_in_ff;
  logic [1:0]   scl_func_ff;
  logic         scl_out_ff;
  logic         scl_in_ff;
  logic         strap_ff;
  logic         strap_done_ff;
  pcs_clk_src_t div_src_ff;
  pcs_clk_src_t pll_src_ff;
  logic [3:0]   pll_n_ff;
  logic         sda_oe_ff;
  logic         scl_oe_ff;
  pcs_rsp_t     rsp_ff;
  logic [7:0]   nxt_rdata;

  wire wr_pin = reg_req.wr && reg_req.addr == PCS_OFS_PIN_CTRL;
  wire wr_clk = reg_req.wr && reg_req.addr == PCS_OFS_CLK_CTRL;

  // ****************************************
  // Pin function control
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_func_ff <= PCS_FUNC_RST;
      sda_out_ff  <= PCS_OUT_RST;
      scl_func_ff <= PCS_FUNC_RST;
      scl_out_ff  <= PCS_OUT_RST;
    end
    else if (wr_pin)
    begin
      sda_func_ff <= reg_req.wdata[PCS_SDA_FUNC_LSB +: 2];
      sda_out_ff  <= reg_req.wdata[PCS_SDA_OUT_BIT];
      scl_func_ff <= reg_req.wdata[PCS_SCL_FUNC_LSB +: 2];
      scl_out_ff  <= reg_req.wdata[PCS_SCL_OUT_BIT];
    end
  end

  // ****************************************
  // Open-drain drive
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end
    else
    begin
      sda_oe_ff <= pin_pull(sda_func_ff, sda_out_ff, bus_sda_pull);
      scl_oe_ff <= pin_pull(scl_func_ff, scl_out_ff, bus_scl_pull);
    end
  end

  assign sda_o  = 1'b0;
  assign scl_o  = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign scl_oe = scl_oe_ff;

  // ****************************************
  // Input sampling
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_in_ff <= 1'b0;
      scl_in_ff <= 1'b0;
    end
    else
    begin
      if (pin_mode(sda_func_ff) == PCS_PIN_GPI)
        sda_in_ff <= sda_i;
      if (pin_mode(scl_func_ff) == PCS_PIN_GPI)
        scl_in_ff <= scl_i;
    end
  end

  // ****************************************
  // Address strap capture
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_ff      <= 1'b0;
      strap_done_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_ff      <= addr_strap;
      strap_done_ff <= 1'b1;
    end
  end

  always_comb
  begin
    if (CODEC_B)
      bus_addr = strap_ff ? PCS_ADDR_B_HIGH : PCS_ADDR_B_LOW;
    else
      bus_addr = strap_ff ? PCS_ADDR_A_HIGH : PCS_ADDR_A_LOW;
  end

  // ****************************************
  // Clock generation control
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_src_ff <= pcs_clk_src_t'(PCS_SRC_RST);
      pll_src_ff <= pcs_clk_src_t'(PCS_SRC_RST);
      pll_n_ff   <= PCS_PLL_N_RST;
    end
    else if (wr_clk)
    begin
      // Reserved source code is refused; previous source kept
      if (reg_req.wdata[PCS_DIV_SRC_LSB +: 2] != PCS_SRC_RSVD)
        div_src_ff <= pcs_clk_src_t'(reg_req.wdata[PCS_DIV_SRC_LSB +: 2]);
      if (reg_req.wdata[PCS_PLL_SRC_LSB +: 2] != PCS_SRC_RSVD)
        pll_src_ff <= pcs_clk_src_t'(reg_req.wdata[PCS_PLL_SRC_LSB +: 2]);
      pll_n_ff <= reg_req.wdata[PCS_PLL_N_LSB +: 4];
    end
  end

  assign divider_input_clock = div_src_ff;
  assign pll_input_clock     = pll_src_ff;
  assign pll_n_value = (pll_n_ff < 4'h2) ? (PCS_PLL_N_WRAP + {1'b0, pll_n_ff})
                                         : {1'b0, pll_n_ff};

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    nxt_rdata = 8'h00;
    case (reg_req.addr)
      PCS_OFS_PIN_CTRL:
      begin
        nxt_rdata[PCS_SDA_FUNC_LSB +: 2] = sda_func_ff;
        nxt_rdata[PCS_SDA_OUT_BIT]       = sda_out_ff;
        nxt_rdata[PCS_SDA_IN_BIT]        = sda_in_ff;
        nxt_rdata[PCS_SCL_FUNC_LSB +: 2] = scl_func_ff;
        nxt_rdata[PCS_SCL_OUT_BIT]       = scl_out_ff;
        nxt_rdata[PCS_SCL_IN_BIT]        = scl_in_ff;
      end
      PCS_OFS_ADDR_STAT: nxt_rdata[PCS_STRAP_BIT] = strap_ff;
      PCS_OFS_CLK_CTRL:
      begin
        nxt_rdata[PCS_DIV_SRC_LSB +: 2] = div_src_ff;
        nxt_rdata[PCS_PLL_SRC_LSB +: 2] = pll_src_ff;
        nxt_rdata[PCS_PLL_N_LSB +: 4]   = pll_n_ff;
      end
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.valid <= reg_req.rd;
      rsp_ff.data  <= reg_req.rd ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rsp = rsp_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_sda_gpo_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_mode(sda_func_ff) == PCS_PIN_GPO && !wr_pin) |=> (sda_oe == !$past(sda_out_ff)))
    else $error("data pin output drive wrong");

  a_scl_gpo_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_mode(scl_func_ff) == PCS_PIN_GPO && !wr_pin) |=> (scl_oe == !$past(scl_out_ff)))
    else $error("clock pin output drive wrong");

  a_pins_low_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (sda_o == 1'b0) && (scl_o == 1'b0))
    else $error("control-bus pin driven high");

  a_sda_gpi_sample: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_mode(sda_func_ff) == PCS_PIN_GPI) ##1 reg_req.rd && reg_req.addr == PCS_OFS_PIN_CTRL
    |=> reg_rsp.data[PCS_SDA_IN_BIT] == $past(sda_i, 2))
    else $error("data pin input value stale");

  a_scl_gpi_sample: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_mode(scl_func_ff) == PCS_PIN_GPI) ##1 reg_req.rd && reg_req.addr == PCS_OFS_PIN_CTRL
    |=> reg_rsp.data[PCS_SCL_IN_BIT] == $past(scl_i, 2))
    else $error("clock pin input value stale");

  a_gpi_no_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_mode(sda_func_ff) == PCS_PIN_GPI) [*2] |-> !sda_oe)
    else $error("data pin driven in input mode");

  a_bus_addr_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
    strap_done_ff |-> bus_addr[0] == CODEC_B && bus_addr[1] == strap_ff
                      && bus_addr[6:2] == 5'h06)
    else $error("bus address does not follow strap");

  a_stat_reserved: assert property (@(posedge sys_clk) disable iff (!arst_n)
    reg_req.rd && reg_req.addr == PCS_OFS_ADDR_STAT
    |=> reg_rsp.valid && reg_rsp.data[7] == 1'b0 && reg_rsp.data[5:0] == 6'h00)
    else $error("reserved status bits not zero");

  a_pll_n_range: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_clk |=> pll_n_value == ($past(reg_req.wdata[3:0]) == 4'h0 ? 5'h10 :
               $past(reg_req.wdata[3:0]) == 4'h1 ? 5'h11 : $past({1'b0, reg_req.wdata[3:0]})))
    else $error("pll divider value wrong");

  a_src_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_clk && reg_req.wdata[7:6] != 2'h3 |=> divider_input_clock == $past(reg_req.wdata[7:6]))
    else $error("divider source not updated");

endmodule : pcs_regs

// >>> tb/pcs_pin_model.sv
`timescale 1ns/100ps
module pcs_pin_model
(
  input  wire logic sda_o,
  input  wire logic sda_oe,
  input  wire logic scl_o,
  input  wire logic scl_oe,
  input  wire logic ext_sda_low,
  input  wire logic ext_scl_low,
  output logic      sda_i,
  output logic      scl_i
);
  // Wired-AND, external pullup gives high
  assign sda_i = !((sda_oe && !sda_o) || ext_sda_low);
  assign scl_i = !((scl_oe && !scl_o) || ext_scl_low);
endmodule : pcs_pin_model

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import pcs_pkg::*;
;
  logic         sys_clk = 1'b0;
  logic         strap = 1'b1;
  logic         arst_n = 1'b0;
  pcs_req_t     req = '0;
  pcs_rsp_t     rsp_a, rsp_b;
  logic         sda_pull = 1'b0, scl_pull = 1'b0;
  logic         ext_sda = 1'b0, ext_scl = 1'b0;
  logic         sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe;
  logic [6:0]   addr_a, addr_b;
  pcs_clk_src_t div_src, pll_src;
  logic [4:0]   pll_n;
  logic [7:0]   exp_q[$];
  logic [7:0]   d, prev;
  logic [31:0]  rng = 32'h5;
  int           n_fail = 0, checks = 0;
  logic [7:0]   pw[7] = '{8'h80, 8'hA0, 8'h08, 8'h0A, 8'h88, 8'h00, 8'h44};
  logic [7:0]   po[7] = '{8'h3, 8'h1, 8'h3, 8'h2, 8'h3, 8'h3, 8'h0};

  always #4 sys_clk = ~sys_clk;

  pcs_regs #(.CODEC_B(1'b0)) pcs_regs_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req),
    .reg_rsp(rsp_a), .bus_sda_pull(sda_pull), .bus_scl_pull(scl_pull), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .addr_strap(strap), .bus_addr(addr_a), .divider_input_clock(div_src),
    .pll_input_clock(pll_src), .pll_n_value(pll_n));
  pcs_regs #(.CODEC_B(1'b1)) pcs_regs_b_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req),
    .reg_rsp(rsp_b), .bus_sda_pull(sda_pull), .bus_scl_pull(scl_pull), .sda_i(sda_i),
    .sda_o(), .sda_oe(), .scl_i(scl_i), .scl_o(), .scl_oe(), .addr_strap(~strap),
    .bus_addr(addr_b), .divider_input_clock(), .pll_input_clock(), .pll_n_value());
  pcs_pin_model pcs_pin_model_i (.sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o),
    .scl_oe(scl_oe), .ext_sda_low(ext_sda), .ext_scl_low(ext_scl), .sda_i(sda_i),
    .scl_i(scl_i));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] wd);
    req = '{1'b1, 1'b0, a, wd};
    @(posedge sys_clk);
    #1 req = '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    #1 req = '0;
  endtask : reg_rd

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Read response monitor
  // ****************************************
  always @(negedge sys_clk)
    if (rsp_a.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(rsp_a.data, 8'hXX);
      else
        chk(rsp_a.data, exp_q.pop_front());
    end

  initial
  begin
    #40000;
    n_fail++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    tick(20);
    arst_n = 1'b1;
    tick(2);
    chk({1'b0, addr_a}, 8'h1A);
    chk({1'b0, addr_b}, 8'h19);
    chk({3'h0, pll_n}, 8'h02);
    reg_rd(PCS_OFS_PIN_CTRL, 8'h00);
    reg_rd(PCS_OFS_ADDR_STAT, 8'h40);
    chk({7'h0, rsp_b.valid}, 8'h01);
    chk(rsp_b.data, 8'h00);
    reg_rd(PCS_OFS_CLK_CTRL, 8'h02);
    reg_wr(PCS_OFS_ADDR_STAT, 8'hFF);
    reg_rd(PCS_OFS_ADDR_STAT, 8'h40);
    reg_rd(8'h67, 8'h00);
    $display("reset and status test done");
    sda_pull = 1'b1;
    scl_pull = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      reg_wr(PCS_OFS_PIN_CTRL, pw[i]);
      tick(1);
      chk({6'h0, sda_oe, scl_oe}, po[i]);
      chk({6'h0, sda_o, scl_o}, 8'h00);
      tick(2);
      reg_rd(PCS_OFS_PIN_CTRL, (i == 6) ? 8'h55 : pw[i]);
    end
    $display("pin mode test done");
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      ext_sda = rng[0];
      ext_scl = rng[1];
      tick(2);
      reg_rd(PCS_OFS_PIN_CTRL, {3'b010, ~rng[0], 3'b010, ~rng[1]});
    end
    $display("pin input test done");
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      d = {2'(rng[7:0] % 3), 2'(rng[15:8] % 3), 4'(i)};
      reg_wr(PCS_OFS_CLK_CTRL, d);
      tick(1);
      chk({3'h0, pll_n}, (i < 2) ? 8'(16 + i) : 8'(i));
      chk({6'h0, div_src}, {6'h0, d[7:6]});
      chk({6'h0, pll_src}, {6'h0, d[5:4]});
      reg_rd(PCS_OFS_CLK_CTRL, d);
    end
    prev = d;
    reg_wr(PCS_OFS_CLK_CTRL, {prev[7:4], 4'h5});
    reg_rd(PCS_OFS_CLK_CTRL, {prev[7:4], 4'h5});
    $display("clock control test done");
    tick(3);
    strap = 1'b0;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(2);
    chk({1'b0, addr_a}, 8'h18);
    chk({1'b0, addr_b}, 8'h1B);
    chk({3'h0, pll_n}, 8'h02);
    reg_rd(PCS_OFS_ADDR_STAT, 8'h00);
    tick(3);
    $display("strap reset test done");
    chk(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule : tb_top
